/* pfs_flag.sv */
`timescale 1ns/1ps
module pfs_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_r
);
  logic flag_nxt;
  always_comb begin
    flag_nxt = flag_r;
    if (clr_in) begin
      flag_nxt = 1'b0;
    end
    // set wins
    if (set_in) begin
      flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end
endmodule

/* pfs_host.sv */
`timescale 1ns/1ps
module pfs_host (
  input logic clk,
  input logic [31:0] cfg_rdata,
  input logic cfg_rvalid,
  output logic cfg_wr = '0,
  output logic cfg_rd = '0,
  output logic [7:0] cfg_addr = '0,
  output logic [3:0] cfg_be = '0,
  output logic [31:0] cfg_wdata = '0
);
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] v, output logic [32:0] d);
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, 4'hC, v};
    @(negedge clk);
    // released address and data flip and strobes drop, so a stale value never passes for a live one
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b0, ~a, ~v};
    d = {cfg_rvalid, cfg_rdata};
  endtask
endmodule

/* pfs_pkg.sv */
// Operation
// - writing one clears a status flag; writing zero leaves it alone
// - bit 15 sets on address or data parity error
// - bit 14 sets when system error signalled while enabled
// - bit 13 sets when our master cycle ends in master abort
// - bit 12 sets when our master cycle gets target abort
// - bit 11 sets when we end a transaction with target abort
// - bits 10:9 read medium select timing code 01
// - bit 8 sets on parity fault, we are master, parity response on
// - bits 7, 6, 5 read zero
// - bus clock at most 33 MHz, so double-speed flag stays zero
// - bit 4 reads one: capability chain present
// - interrupt line asserted only when pending and not disabled
// - interrupt disable never changes the pending bit
// - pending bit only for enabled interrupt conditions
// - bits 2 down to 0 read zero
// - class bits 31:24 read mass storage base category
// - class bits 23:16 read other mass storage subclass
// - class bits 15:8 read zero programming interface
// - class bits 7:0 read fixed silicon revision
// - command bit 8 enables the system fault driver
// - command bit 10 blocks interrupt line, resets to zero
package pfs_pkg;
  localparam logic [7:0]  PFS_OFS_STATUS = 8'h06;
  localparam logic [7:0]  PFS_OFS_CLASS  = 8'h08;
  localparam logic [15:0] PFS_STATUS_RST = 16'h0210;
  localparam int PFS_B_PAR   = 15;
  localparam int PFS_B_SYS   = 14;
  localparam int PFS_B_MAB   = 13;
  localparam int PFS_B_TABR  = 12;
  localparam int PFS_B_TABS  = 11;
  localparam int PFS_B_DPAR  = 8;
  localparam int PFS_B_INT   = 3;
  localparam int PFS_CMD_PERR = 6;
  localparam int PFS_CMD_SERR = 8;
  localparam int PFS_CMD_IDIS = 10;
  localparam logic [1:0]  PFS_DEVSEL_MED = 2'h1;
  localparam logic [7:0]  PFS_BASE_CAT   = 8'h01;
  localparam logic [7:0]  PFS_SUB_CAT    = 8'h80;
  localparam logic [7:0]  PFS_PROG_IF    = 8'h00;
  // clearable flag mask (bits 15..11, 8)
  localparam logic [15:0] PFS_RCU_MASK   = 16'hF900;
  // the six sticky fault events
  typedef struct packed {
    logic parity_fault;
    logic sys_fault;
    logic master_abort;
    logic tabort_rx;
    logic tabort_tx;
    logic data_par;
  } pfs_evt_t;
endpackage

/* pfs_status_class.sv */
`timescale 1ns/1ps
module pfs_status_class
  import pfs_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h00  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [15:0] command,
  input  wire pfs_evt_t    evt,
  input  wire logic        perr_seen,
  input  wire logic        we_are_master,
  input  wire logic        addr_parity_err,
  input  wire logic        int_cond,
  input  wire logic        int_cond_en,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  output logic             int_out_n,
  output logic             serr_oe
);
  //////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  logic [15:0] clr;
  logic [15:0] setv;
  // per-bit drivers from the generate loop, so a net rather than a variable
  wire  logic [15:0] flags;
  logic        int_pend_r;
  logic        int_pend_nxt;
  logic [31:0] rdata_nxt;
  logic        int_n_nxt;
  logic        serr_nxt;
  logic        sys_event;
  logic [15:0] status_word;

  always_comb begin
    clr = 16'h0000;
    // one clears flag; fixed bits ignore writes
    if (cfg_wr && hit(cfg_addr, PFS_OFS_STATUS)) begin
      clr = cfg_wdata[31:16] & {{8{cfg_be[3]}}, {8{cfg_be[2]}}} & PFS_RCU_MASK;
    end
  end

  // system fault driver gated by enable
  assign sys_event = addr_parity_err && command[PFS_CMD_SERR];

  always_comb begin
    setv = 16'h0000;
    setv[PFS_B_PAR]  = evt.parity_fault || addr_parity_err;
    setv[PFS_B_SYS]  = (evt.sys_fault && command[PFS_CMD_SERR]) || sys_event;
    setv[PFS_B_MAB]  = evt.master_abort;
    setv[PFS_B_TABR] = evt.tabort_rx;
    setv[PFS_B_TABS] = evt.tabort_tx;
    setv[PFS_B_DPAR] = (evt.data_par || perr_seen) && we_are_master
                       && command[PFS_CMD_PERR];
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_flag
      if (PFS_RCU_MASK[g]) begin : g_on
        pfs_flag u_flag (
          .clk     (clk),
          .reset_n (reset_n),
          .ce      (ce),
          .set_in  (setv[g]),
          .clr_in  (clr[g]),
          .flag_r  (flags[g])
        );
      end else begin : g_off
        assign flags[g] = 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    // only enabled conditions; disable bit not consulted
    int_pend_nxt = int_cond && int_cond_en;
  end

  always_comb begin
    status_word = flags & PFS_RCU_MASK;
    status_word[10:9] = PFS_DEVSEL_MED;
    status_word[7:0] = PFS_STATUS_RST[7:0];
    status_word[PFS_B_INT] = int_pend_r;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (cfg_rd && hit(cfg_addr, PFS_OFS_STATUS)) begin
      rdata_nxt = {status_word, command & 16'h0000};
    end else if (cfg_rd && hit(cfg_addr, PFS_OFS_CLASS)) begin
      rdata_nxt = {PFS_BASE_CAT, PFS_SUB_CAT, PFS_PROG_IF, SILICON_REV};
    end
    int_n_nxt = !(int_pend_nxt && !command[PFS_CMD_IDIS]);
    serr_nxt  = sys_event;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_pend_r <= 1'b0;
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
      int_out_n  <= 1'b1;
      serr_oe    <= 1'b0;
    end else if (ce) begin
      int_pend_r <= int_pend_nxt;
      cfg_rdata  <= rdata_nxt;
      cfg_rvalid <= cfg_rd;
      int_out_n  <= int_n_nxt;
      serr_oe    <= serr_nxt;
    end
  end
endmodule

/* pfs_status_class_sva.sv */
`timescale 1ns/1ps
module pfs_status_class_sva (
  input logic clk,
  input logic reset_n,
  input logic ce,
  input logic cfg_rd,
  input logic [7:0] cfg_addr,
  input logic [15:0] command,
  input logic int_cond,
  input logic int_cond_en,
  input logic [31:0] cfg_rdata,
  input logic cfg_rvalid,
  input logic int_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic rs = ce && cfg_rd && cfg_addr[7:2] == 6'h01;
  wire logic rc = ce && cfg_rd && cfg_addr[7:2] == 6'h02;
  a_read_answer: assert property (ce && cfg_rd |=> cfg_rvalid) else $error("rv");
  a_idle_quiet: assert property (ce && !cfg_rd |=> !cfg_rvalid) else $error("rv");
  a_class_word: assert property (rc |=> cfg_rdata == 32'h01800000) else $error("cls");
  a_devsel_code: assert property (rs |=> cfg_rdata[26:25] == 2'h1) else $error("dev");
  a_fixed_bits: assert property (rs |=> (cfg_rdata[23:16] & 8'hF7) == 8'h10)
    else $error("fix");
  a_int_assert: assert property (ce && int_cond && int_cond_en && !command[10] |=> !int_out_n)
    else $error("int");
  a_int_block: assert property (ce && command[10] |=> int_out_n) else $error("int");
  a_int_idle: assert property (ce && !(int_cond && int_cond_en) |=> int_out_n)
    else $error("int");
  c_int: cover property (!int_out_n);
  c_class: cover property (rc ##1 cfg_rvalid);
  c_block: cover property (command[10] && int_cond);
endmodule

/* pfs_status_class_tb.sv */
`timescale 1ns/1ps
bind pfs_status_class pfs_status_class_sva u_sva (.*);
module pfs_status_class_tb;
  logic clk = '0, reset_n = '0, perr_seen = '0, we_are_master = '0, addr_parity_err = '0;
  logic int_cond = '0, int_cond_en = '0, cfg_wr, cfg_rd, cfg_rvalid, int_out_n, serr_oe;
  logic [15:0] command = '0;
  logic ce = 1'b1;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [32:0] d;
  pfs_pkg::pfs_evt_t evt = '0;
  int error_cnt = 0, compares = 0;
  int b[6] = '{8, 11, 12, 13, 14, 15};
  initial forever #20 clk = ~clk;
  pfs_status_class DUT (.*);
  pfs_host h (.*);
  task automatic chk(string n, logic [32:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // d is {valid, data}; m keeps only the bits a check owns
  task automatic rdm(string n, logic [7:0] a, logic [32:0] m, e);
    h.xfer(1'b0, a, 32'h0, d);
    chk(n, d & m, e);
  endtask
  task automatic s_class;
    h.xfer(1'b1, 8'h08, '1, d);
    rdm("class", 8'h08, '1, 33'h101800000);
    rdm("unmapped", 8'h40, '1, 33'h100000000);
  endtask
  // data parity flag needs master role and parity response on
  task automatic s_flags;
    command = 16'h0140;
    we_are_master = 1'b1;
    for (int i = 0; i < 6; i++) begin
      evt = 6'h1 << i;
      h.xfer(1'b1, 8'h04, 32'h0, d);
      evt = '0;
      rdm("flag", 8'h04, '1, 33'h102100000 | 33'h1 << (b[i] + 16));
      h.xfer(1'b1, 8'h04, 32'hFFFF0000, d);
      rdm("clear", 8'h04, '1, 33'h102100000);
    end
  endtask
  task automatic s_int;
    {int_cond, int_cond_en} = 2'b11;
    rdm("pend", 8'h04, 33'h100080000, 33'h100080000);
    chk("int_on", int_out_n, 1'b0);
    command = 16'h0400;
    rdm("kept", 8'h04, 33'h100080000, 33'h100080000);
    chk("int_off", int_out_n, 1'b1);
    {int_cond_en, command, addr_parity_err} = {1'b0, 16'h0100, 1'b1};
    h.xfer(1'b1, 8'h04, 32'hFFFF0000, d);
    chk("serr", serr_oe, 1'b1);
    rdm("sys", 8'h04, 33'h140080000, 33'h140000000);
    {int_cond, addr_parity_err} = 2'b00;
  endtask
  // an event while the enable is low must leave no trace
  task automatic s_hold;
    ce = 1'b0;
    evt = 6'h02;
    repeat (3) @(negedge clk);
    evt = '0;
    ce = 1'b1;
    rdm("hold", 8'h04, 33'h108000000, 33'h100000000);
  endtask
  // a reset in mid-run brings back the default status
  task automatic s_rst;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    rdm("rst2", 8'h04, '1, 33'h102100000);
  endtask
  task automatic test_done;
    $display("errors %0d of %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    rdm("reset", 8'h04, '1, 33'h102100000);
    s_class;
    s_flags;
    s_int;
    s_hold;
    s_rst;
    test_done;
  end
endmodule
